// File: src/vme_buffer_interrupt_control.sv
// interrupt status, enable, vector and swap snoop logic
// Functional notes
// - request when any enabled status bit set
// - bus reset clears every status bit
// - dma level four request sets bit 7
// - dma level three request sets bit 6
// - level two/one from either source
// - writing one clears that status bit
// - remote correctable ecc error sets bit 2
// - soft flag may accompany hard flag
// - remote uncorrectable ecc error sets bit 1
// - local ram parity error sets bit 0
// - enable bit gates same status bit
// - enable bits read/write, reset to zero
// - snoop captures a buffer ram write, else a read
// - writes capture swapper output data
// - reads capture raw ram data
// - dma level field codes 0..3 give 1..4
// - dma completion requests only when enabled
// - ack vector is base then dma vector
`default_nettype none
module vme_buffer_interrupt_control
   import irq_pkg::*;
(
   input wire logic clock,
   input wire logic rst,                 // extended vme bus reset
   // register port
   input wire logic reg_wr,              // write strobe
   input wire logic reg_rd,              // read strobe
   input wire logic [1:0] reg_sel,       // register select
   input wire logic [irq_pkg::DATA_W-1:0] reg_wdata,
   output logic [irq_pkg::DATA_W-1:0] reg_rdata,
   // event sources
   input wire logic dma_done,            // dma completion pulse
   input wire logic dma_irq_enable,      // dma interrupt enable
   input wire logic [1:0] dma_irq_level_field,
   input wire logic [5:0] dma_vector_field,
   input wire logic [1:0] vector_base_field,
   input wire logic tc_request_lvl_two,  // transaction controller
   input wire logic tc_request_lvl_one,
   input wire logic remote_soft_ecc_flag,
   input wire logic remote_hard_ecc_flag,
   input wire logic local_ram_parity_flag,
   // buffer ram data path
   input wire logic ram_wr,
   input wire logic ram_rd,
   input wire logic [irq_pkg::DATA_W-1:0] swap_out_data,
   input wire logic [irq_pkg::DATA_W-1:0] ram_read_data,
   // vme interrupt side
   input wire logic irq_ack,             // acknowledge cycle
   output logic irq_request,             // request on the bus
   output logic [7:0] irq_vector,        // vector for the data bus
   output logic irq_vector_valid
);
   import irq_pkg::*;

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [STAT_W-1:0] interrupt_status_reg; // sticky status
   logic [STAT_W-1:0] interrupt_status_next;
   logic [STAT_W-1:0] interrupt_enable_reg; // enable mask
   logic [DATA_W-1:0] swapper_snoop_reg;    // snoop data
   logic [7:0] vector_reg;                  // vector held for ack
   logic vector_valid_reg;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   // write strobes per register; snoop and code 3 take none
   wire wr_status = reg_wr && (reg_sel == SEL_STATUS);
   wire wr_enable = reg_wr && (reg_sel == SEL_ENABLE);
   // dma level decode, one request bit per level code
   // a completion with the enable low raises nothing
   logic [DMA_LVLS-1:0] dma_lvl;
   for (genvar i = 0; i < DMA_LVLS; i++) begin : g_lvl
      // code i selects bus level i+1
      assign dma_lvl[i] = dma_done && dma_irq_enable &&
         (dma_irq_level_field == 2'(i));
   end
   // hardware set vector
   logic [STAT_W-1:0] set_vec;
   assign set_vec[BIT_LVL4] = dma_lvl[3];
   assign set_vec[BIT_LVL3] = dma_lvl[2];
   assign set_vec[BIT_LVL2] = dma_lvl[1] || tc_request_lvl_two;
   assign set_vec[BIT_LVL1] = dma_lvl[0] || tc_request_lvl_one;
   assign set_vec[BIT_SPARE] = 1'b0;
   // soft flag taken as reported, even beside hard
   assign set_vec[BIT_SOFT] = remote_soft_ecc_flag;
   assign set_vec[BIT_HARD] = remote_hard_ecc_flag;
   assign set_vec[BIT_PAR] = local_ram_parity_flag;
   // write one to clear, set wins over clear
   wire [STAT_W-1:0] clr_vec = wr_status ? reg_wdata[STAT_W-1:0] :
      STAT_RESET;
   assign interrupt_status_next = ((interrupt_status_reg & ~clr_vec) |
      set_vec) & USED_MASK;

   // ----------------------------------------
   // status and enable registers
   // ----------------------------------------
   // both cleared by bus reset; status folds set and clear
   // in one next value so an event never slips past a clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         interrupt_status_reg <= STAT_RESET;
         interrupt_enable_reg <= EN_RESET;
      end else begin
         interrupt_status_reg <= interrupt_status_next;
         if (wr_enable) begin
            // unused positions never store a one
            interrupt_enable_reg <=
               reg_wdata[STAT_W-1:0] & USED_MASK;
         end
      end
   end

   // ----------------------------------------
   // swap snoop
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         swapper_snoop_reg <= SNOOP_RESET;
      // a write wins when both strobes meet
      end else if (ram_wr) begin
         swapper_snoop_reg <= swap_out_data;
      end else if (ram_rd) begin
         swapper_snoop_reg <= ram_read_data;
      end
   end

   // ----------------------------------------
   // vector for acknowledge
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         vector_reg <= 8'h00;
         vector_valid_reg <= 1'b0;
      end else begin
         vector_reg <= {vector_base_field, dma_vector_field};
         vector_valid_reg <= irq_ack;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // request is combinational so a clear drops it at once
   assign irq_request =
      |(interrupt_status_reg & interrupt_enable_reg);
   // vector and valid straight from flip-flops
   assign irq_vector = vector_reg;
   assign irq_vector_valid = vector_valid_reg;
   // read mux, unused bits zero
   assign reg_rdata = !reg_rd ? READ_ZERO :
      (reg_sel == SEL_STATUS) ? {24'h000000, interrupt_status_reg} :
      (reg_sel == SEL_ENABLE) ? {24'h000000, interrupt_enable_reg} :
      (reg_sel == SEL_SNOOP) ? swapper_snoop_reg : READ_ZERO;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // request follows enabled status at every edge
   request_gate_a: assert property (
      @(posedge clock) disable iff (rst)
      irq_request == |(interrupt_status_reg & interrupt_enable_reg))
      else $error("request does not follow status and enable");

   // a cleared mask keeps the request line quiet
   masked_quiet_a: assert property (
      @(posedge clock) disable iff (rst)
      interrupt_enable_reg == EN_RESET |-> !irq_request)
      else $error("request raised with every enable clear");

   // a one written to a bit clears it when no event meets it
   clear_one_a: assert property (
      @(posedge clock) disable iff (rst)
      wr_status && reg_wdata[BIT_PAR] && !local_ram_parity_flag
      |=> !interrupt_status_reg[BIT_PAR])
      else $error("status bit not cleared by one");

   // a set bit stays unless a one is written to it
   status_sticky_a: assert property (
      @(posedge clock) disable iff (rst)
      interrupt_status_reg[BIT_HARD] && !(wr_status && reg_wdata[BIT_HARD])
      |=> interrupt_status_reg[BIT_HARD])
      else $error("status bit lost without a clear");

   // parity event recorded, set wins over clear
   set_par_a: assert property (
      @(posedge clock) disable iff (rst)
      local_ram_parity_flag |=> interrupt_status_reg[BIT_PAR])
      else $error("parity flag not recorded");

   // correctable remote error recorded
   soft_set_a: assert property (
      @(posedge clock) disable iff (rst)
      remote_soft_ecc_flag |=> interrupt_status_reg[BIT_SOFT])
      else $error("soft error flag not recorded");

   // uncorrectable remote error recorded
   hard_set_a: assert property (
      @(posedge clock) disable iff (rst)
      remote_hard_ecc_flag |=> interrupt_status_reg[BIT_HARD])
      else $error("hard error flag not recorded");

   // dma completion at code 3 lands on level four
   dma_lvl4_a: assert property (
      @(posedge clock) disable iff (rst)
      dma_done && dma_irq_enable && dma_irq_level_field == LVL_CODE_4
      |=> interrupt_status_reg[BIT_LVL4])
      else $error("level four request lost");

   // dma completion at code 2 lands on level three
   dma_lvl3_a: assert property (
      @(posedge clock) disable iff (rst)
      dma_done && dma_irq_enable && dma_irq_level_field == LVL_CODE_3
      |=> interrupt_status_reg[BIT_LVL3])
      else $error("level three request lost");

   // dma completion at code 1 lands on level two
   dma_lvl2_a: assert property (
      @(posedge clock) disable iff (rst)
      dma_done && dma_irq_enable && dma_irq_level_field == LVL_CODE_2
      |=> interrupt_status_reg[BIT_LVL2])
      else $error("level two request lost");

   // transaction controller request lands on level one
   tc_lvl1_a: assert property (
      @(posedge clock) disable iff (rst)
      tc_request_lvl_one |=> interrupt_status_reg[BIT_LVL1])
      else $error("level one request lost");

   // only the dma sets level three, and not while disabled
   dma_off_a: assert property (
      @(posedge clock) disable iff (rst)
      !dma_irq_enable && !interrupt_status_reg[BIT_LVL3]
      |=> !interrupt_status_reg[BIT_LVL3])
      else $error("disabled dma raised level three");

   // spare position never holds a one
   unused_zero_a: assert property (
      @(posedge clock) disable iff (rst)
      !interrupt_status_reg[BIT_SPARE] && !interrupt_enable_reg[BIT_SPARE])
      else $error("unused bit set");

   // enable write stored with unused bits dropped
   enable_write_a: assert property (
      @(posedge clock) disable iff (rst)
      wr_enable |=> interrupt_enable_reg ==
      ($past(reg_wdata[STAT_W-1:0]) & USED_MASK))
      else $error("enable write not stored");

   // enable changes only by its own write
   enable_hold_a: assert property (
      @(posedge clock) disable iff (rst)
      !wr_enable |=> $stable(interrupt_enable_reg))
      else $error("enable changed without a write");

   // write access captures swapper output
   snoop_write_a: assert property (
      @(posedge clock) disable iff (rst)
      ram_wr |=> swapper_snoop_reg == $past(swap_out_data))
      else $error("snoop missed write data");

   // read access captures raw ram data
   snoop_read_a: assert property (
      @(posedge clock) disable iff (rst)
      ram_rd && !ram_wr |=> swapper_snoop_reg == $past(ram_read_data))
      else $error("snoop missed read data");

   // no ram access, snoop holds its last capture
   snoop_hold_a: assert property (
      @(posedge clock) disable iff (rst)
      !ram_wr && !ram_rd |=> $stable(swapper_snoop_reg))
      else $error("snoop changed without an access");

   // acknowledge cycle seen from the bus side
   sequence ack_seen_s;
      irq_ack;
   endsequence

   // vector valid with the fields taken at the acknowledge
   sequence vector_shown_s;
      irq_vector_valid &&
      irq_vector == $past({vector_base_field, dma_vector_field});
   endsequence

   // acknowledge answered by the vector one cycle later
   property ack_answer_p;
      @(posedge clock) disable iff (rst)
      ack_seen_s |=> vector_shown_s;
   endproperty

   ack_answer_a: assert property (ack_answer_p)
      else $error("no vector after acknowledge");

   // no valid vector without an acknowledge just before
   vector_only_a: assert property (
      @(posedge clock) disable iff (rst)
      irq_vector_valid |-> $past(irq_ack))
      else $error("vector valid without acknowledge");
endmodule
`default_nettype wire

// File: src/irq_pkg.sv
// constants for the buffer board interrupt control block
`default_nettype none
package irq_pkg;
   localparam int DATA_W = 32;
   localparam int STAT_W = 8;
   // field positions of the status and enable registers
   localparam int BIT_LVL4 = 7;
   localparam int BIT_LVL3 = 6;
   localparam int BIT_LVL2 = 5;
   localparam int BIT_LVL1 = 4;
   localparam int BIT_SOFT = 2;
   localparam int BIT_HARD = 1;
   localparam int BIT_PAR = 0;
   localparam int BIT_SPARE = 3;
   // number of dma request level codes
   localparam int DMA_LVLS = 4;
   // implemented bits; 31..8 and 3 are unused
   localparam logic [STAT_W-1:0] USED_MASK = 8'hF7;
   localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;
   localparam logic [STAT_W-1:0] EN_RESET = 8'h00;
   localparam logic [DATA_W-1:0] SNOOP_RESET = 32'h0000_0000;
   // dma level field codes
   localparam logic [1:0] LVL_CODE_1 = 2'h0;
   localparam logic [1:0] LVL_CODE_2 = 2'h1;
   localparam logic [1:0] LVL_CODE_3 = 2'h2;
   localparam logic [1:0] LVL_CODE_4 = 2'h3;
   // register select codes for the local register port
   localparam logic [1:0] SEL_STATUS = 2'h0;
   localparam logic [1:0] SEL_ENABLE = 2'h1;
   localparam logic [1:0] SEL_SNOOP = 2'h2;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// File: test/vme_irq_handler.sv
// far-side interrupt handler model: acknowledges, keeps the vector
`default_nettype none
module vme_irq_handler (
   input wire logic clock,
   input wire logic rst,
   input wire logic irq_request,
   input wire logic irq_vector_valid,
   input wire logic [7:0] irq_vector,
   output logic irq_ack,
   output logic [7:0] got_vector
);
   timeunit 1ns;
   timeprecision 1ns;
   // answer a standing request with one ack, then wait for the vector
   always_ff @(negedge clock or posedge rst) begin
      if (rst) begin
         irq_ack <= 1'b0;
         got_vector <= 8'h00;
      end else begin
         irq_ack <= irq_request & ~irq_ack & ~irq_vector_valid;
         if (irq_vector_valid) got_vector <= irq_vector;
      end
   end
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the interrupt control block
`default_nettype none
module tb;
   import irq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, dma_irq_enable = 0;
   logic ram_wr = 0, ram_rd = 0, irq_request, irq_vector_valid, irq_ack;
   logic [1:0] reg_sel = 0, dma_irq_level_field = 0, vector_base_field = 0;
   logic [5:0] dma_vector_field = 0;
   logic [7:0] ev = 0, irq_vector, got_vector; // ev[3] is dma_done
   logic [31:0] reg_wdata = 0, reg_rdata, swap_out_data = 0;
   logic [31:0] ram_read_data = 0, v, r;
   int n_errors = 0, total_checks = 0, cycles = 0;
   vme_buffer_interrupt_control dut_u (.clock(clock), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dma_done(ev[3]),
      .dma_irq_enable(dma_irq_enable),
      .dma_irq_level_field(dma_irq_level_field),
      .dma_vector_field(dma_vector_field),
      .vector_base_field(vector_base_field),
      .tc_request_lvl_two(ev[5]), .tc_request_lvl_one(ev[4]),
      .remote_soft_ecc_flag(ev[2]), .remote_hard_ecc_flag(ev[1]),
      .local_ram_parity_flag(ev[0]), .ram_wr(ram_wr), .ram_rd(ram_rd),
      .swap_out_data(swap_out_data), .ram_read_data(ram_read_data),
      .irq_ack(irq_ack), .irq_request(irq_request), .irq_vector(irq_vector),
      .irq_vector_valid(irq_vector_valid));
   vme_irq_handler host_u (.clock(clock), .rst(rst), .irq_request(irq_request),
      .irq_vector_valid(irq_vector_valid), .irq_vector(irq_vector),
      .irq_ack(irq_ack), .got_vector(got_vector));
   // clock and hang guard
   initial forever #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         end_sim();
      end
   end
   task end_sim();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   // expected status word for a dma request at level code c
   function automatic logic [31:0] lvl_bit(input int c);
      return 32'h1 << (BIT_LVL1 + c);
   endfunction
   // register access, a read ends one falling edge later, a write two
   task wr(input logic [1:0] s, input logic [31:0] d);
      reg_sel = s;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask
   task rd(input logic [1:0] s);
      reg_sel = s;
      #1 v = reg_rdata;
      @(negedge clock);
   endtask
   task pulse(input logic [7:0] e);
      ev = e;
      @(negedge clock);
      ev = 8'h00;
      @(negedge clock);
   endtask
   // one buffer ram access, data changed afterwards
   task snoop(input logic w);
      r = $urandom;
      if (w) swap_out_data = r;
      else ram_read_data = r;
      ram_wr = w;
      ram_rd = ~w;
      @(negedge clock);
      ram_wr = 1'b0;
      ram_rd = 1'b0;
      swap_out_data = ~r;
      ram_read_data = ~r;
      @(negedge clock);
      rd(SEL_SNOOP);
   endtask
   initial begin
      void'($urandom(49));
      repeat (20) @(negedge clock);
      rst = 0;
      reg_rd = 1;
      rd(SEL_STATUS);
      chk(v, 0);
      r = $urandom;
      wr(SEL_ENABLE, r);
      rd(SEL_ENABLE);
      chk(v, r[7:0] & USED_MASK);
      wr(SEL_ENABLE, 32'hFFFF_FFFF);
      for (int b = 0; b < 6; b++) begin
         if (b == 3) continue;
         pulse(8'h01 << b);
         rd(SEL_STATUS);
         chk(v, 32'h1 << b);
         chk(irq_request, 1'b1);
         wr(SEL_STATUS, 32'h1 << b);
         rd(SEL_STATUS);
         chk(v, 0);
      end
      // event and clear of the same bit in one cycle: set wins
      ev = 8'h01;
      reg_sel = SEL_STATUS;
      reg_wdata = 32'h1;
      reg_wr = 1'b1;
      @(negedge clock);
      ev = 8'h00;
      reg_wr = 1'b0;
      @(negedge clock);
      rd(SEL_STATUS);
      chk(v, 32'h1);
      wr(SEL_STATUS, 32'h1);
      rd(SEL_STATUS);
      chk(v, 0);
      dma_irq_enable = 1;
      for (int c = 0; c < 4; c++) begin
         dma_irq_level_field = c[1:0];
         pulse(8'h08);
         rd(SEL_STATUS);
         chk(v, lvl_bit(c));
         wr(SEL_STATUS, 32'hFF);
      end
      dma_irq_enable = 0;
      pulse(8'h08);
      rd(SEL_STATUS);
      chk(v, 0);
      r = $urandom;
      pulse(8'h37);
      wr(SEL_STATUS, r);
      rd(SEL_STATUS);
      chk(v, 8'h37 & ~r[7:0]);
      pulse(8'h37);
      wr(SEL_ENABLE, 0);
      chk(irq_request, 1'b0);
      wr(SEL_ENABLE, 32'h02);
      chk(irq_request, 1'b1);
      wr(SEL_STATUS, 32'h02);
      chk(irq_request, 1'b0);
      wr(2'h3, 32'hFFFF_FFFF);
      rd(2'h3);
      chk(v, 0);
      rd(SEL_STATUS);
      chk(v, 32'h35);
      snoop(1'b1);
      chk(v, r);
      snoop(1'b0);
      chk(v, r);
      wr(SEL_SNOOP, ~r);
      rd(SEL_SNOOP);
      chk(v, r);
      r = $urandom;
      {vector_base_field, dma_vector_field} = r[7:0];
      pulse(8'h02);
      for (int i = 0; i < 20 && got_vector !== r[7:0]; i++) @(negedge clock);
      chk(got_vector, r[7:0]);
      rst = 1;
      @(negedge clock);
      rst = 0;
      rd(SEL_STATUS);
      chk(v, 0);
      rd(SEL_ENABLE);
      chk(v, 0);
      end_sim();
   end
endmodule
`default_nettype wire
